// >>> led_ctrl_pkg.sv
// Constants shared by the LED sink control register design
package led_ctrl_pkg;

  // Bus addressing
  localparam logic [6:0] DEV_ADDR      = 7'h36;  // Seven-bit bus address of the device
  localparam logic [7:0] GC_ADDR       = 8'h10;  // Register address of general_control
  localparam logic [7:0] UNMAPPED_READ = 8'h00;  // Read value of any other register address
  localparam logic [3:0] BYTE_BITS     = 4'h8;   // Bits in one bus byte

  // general_control layout and reset
  localparam logic [7:0] GC_RESET      = 8'hc0;  // Power-on value
  localparam logic [7:0] GC_FIXED_MASK = 8'hc0;  // Bits 7 and 6 always read as one
  localparam int PRIMARY_EN_BIT   = 0;           // primary_sink_enable
  localparam int SECONDARY_EN_BIT = 1;           // secondary_sink_enable
  localparam int SHARED_LEVEL_BIT = 2;           // shared_level_select
  localparam int RAMP_LOW_BIT     = 3;           // ramp_rate_bit_low
  localparam int RAMP_HIGH_BIT    = 4;           // ramp_rate_bit_high
  localparam int DISPLAY_BIAS_BIT = 5;           // display_bias_mode

  // Clock and ramp step times
  localparam int CLK_PERIOD_NS  = 4;             // System clock period
  localparam int RAMP_STEP_A_US = 51;            // Step time, low bit 0, high bit 0
  localparam int RAMP_STEP_B_MS = 13;            // Step time, low bit 0, high bit 1
  localparam int RAMP_STEP_C_MS = 26;            // Step time, low bit 1, high bit 0
  localparam int RAMP_STEP_D_MS = 52;            // Step time, low bit 1, high bit 1

  // Ramp step periods in clock cycles
  localparam logic [23:0] RAMP_CYC_A = 24'(RAMP_STEP_A_US * 1000 / CLK_PERIOD_NS);
  localparam logic [23:0] RAMP_CYC_B = 24'(RAMP_STEP_B_MS * 1000000 / CLK_PERIOD_NS);
  localparam logic [23:0] RAMP_CYC_C = 24'(RAMP_STEP_C_MS * 1000000 / CLK_PERIOD_NS);
  localparam logic [23:0] RAMP_CYC_D = 24'(RAMP_STEP_D_MS * 1000000 / CLK_PERIOD_NS);

  // Bus slave states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_MACK
  } bus_state_type;

endpackage

// >>> bus_event_if.sv
// Bus condition events passed from the pin front end to the slave
`timescale 1ns/100ps
interface bus_event_if;
  logic startSeen;  // Start or repeated start, one-cycle pulse
  logic stopSeen;   // Stop, one-cycle pulse
  logic sclRise;    // Clock rising edge, one-cycle pulse
  logic sclFall;    // Clock falling edge, one-cycle pulse
  logic sdaLevel;   // Synchronised data level

  modport source (output startSeen, stopSeen, sclRise, sclFall, sdaLevel);
  modport sink   (input  startSeen, stopSeen, sclRise, sclFall, sdaLevel);
endinterface

// >>> pin_sync.sv
// Two-stage synchroniser for the bus pins
`timescale 1ns/100ps
module pin_sync (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] pinIn,
  output logic      [1:0] pinSync
);

  // One pair of flip-flops per pin; idle bus lines are high
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_sync
      logic stage1_reg;  // Metastability stage, read only by stage2
      logic stage2_reg;  // Stable copy

      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          stage1_reg <= 1'b1;
          stage2_reg <= 1'b1;
        end else begin
          stage1_reg <= pinIn[i];
          stage2_reg <= stage1_reg;
        end
      end

      assign pinSync[i] = stage2_reg;
    end
  endgenerate

endmodule

// >>> bus_condition_detect.sv
// Start, stop and clock edge detection on synchronised bus lines
`timescale 1ns/100ps
module bus_condition_detect (
  input  wire logic    ref_clk,
  input  wire logic    rst_b,
  input  wire logic    sclSync,
  input  wire logic    sdaSync,
  bus_event_if.source  ev
);

  logic sclPrev_reg;   // Clock level one cycle ago
  logic sdaPrev_reg;   // Data level one cycle ago
  logic start_reg;     // Start pulse
  logic stop_reg;      // Stop pulse
  logic rise_reg;      // Clock rise pulse
  logic fall_reg;      // Clock fall pulse
  logic start_next;
  logic stop_next;
  logic rise_next;
  logic fall_next;

  // Data edges while the clock stays high mark start and stop
  always_comb begin
    start_next = sclPrev_reg & sclSync & sdaPrev_reg & ~sdaSync;
    stop_next  = sclPrev_reg & sclSync & ~sdaPrev_reg & sdaSync;
    rise_next  = ~sclPrev_reg & sclSync;
    fall_next  = sclPrev_reg & ~sclSync;
  end

  // Register levels and pulses
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      start_reg   <= 1'b0;
      stop_reg    <= 1'b0;
      rise_reg    <= 1'b0;
      fall_reg    <= 1'b0;
    end else begin
      sclPrev_reg <= sclSync;
      sdaPrev_reg <= sdaSync;
      start_reg   <= start_next;
      stop_reg    <= stop_next;
      rise_reg    <= rise_next;
      fall_reg    <= fall_next;
    end
  end

  assign ev.startSeen = start_reg;
  assign ev.stopSeen  = stop_reg;
  assign ev.sclRise   = rise_reg;
  assign ev.sclFall   = fall_reg;
  assign ev.sdaLevel  = sdaPrev_reg;

endmodule

// >>> led_sink_general_control_register.sv
// General control register of a two-output LED driver with bus slave and sink decode
// Operation
// - Bit 0 set enables primary sink
// - Bit 0 clear disables primary, output floats
// - Bit 1 set enables secondary sink in independent mode
// - Bit 1 clear disables secondary in independent mode, output floats
// - Bit 2 set: primary level drives both
// - Bit 2 clear: each sink own level
// - Bits 4:3 select ramp step rate
// - Bit 5 clear: both sinks usable
// - Bit 5 set: secondary off, feedback pin
// - Bias mode: primary follows bit 0
// - Bits 7:6 unused, read as one
// - Shared, primary on: both sinks on
// - Shared, primary off: both sinks off
// - Independent, only secondary on: secondary only
// - Independent, only primary on: primary only
// - Analog enable when bit 0, 1 or 5
// - Register resets to c0 hex
`timescale 1ns/100ps
module led_sink_general_control_register
  import led_ctrl_pkg::*;
#(
  parameter logic [23:0] STEP_CYCLES_A = RAMP_CYC_A,  // Ramp step period, rate 0
  parameter logic [23:0] STEP_CYCLES_B = RAMP_CYC_B,  // Ramp step period, rate 2
  parameter logic [23:0] STEP_CYCLES_C = RAMP_CYC_C,  // Ramp step period, rate 1
  parameter logic [23:0] STEP_CYCLES_D = RAMP_CYC_D   // Ramp step period, rate 3
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe_b,
  output logic            primarySinkOn,
  output logic            secondarySinkOn,
  output logic            secondaryLevelFromPrimary,
  output logic            feedbackMode,
  output logic            analogEnable,
  output logic      [1:0] rampRate,
  output logic            rampStepTick
);

  bus_event_if ev ();          // Bus events from the front end
  logic [1:0]  pinSync;        // Synchronised clock and data

  // Slave state
  bus_state_type state_reg;     // Current slave state
  bus_state_type state_next;
  bus_state_type afterAck_reg;  // State to enter after the acknowledge bit
  bus_state_type afterAck_next;
  logic [7:0]  shift_reg;       // Byte shift register
  logic [7:0]  shift_next;
  logic [3:0]  bitCount_reg;    // Bits of the current byte seen
  logic [3:0]  bitCount_next;
  logic [7:0]  regPtr_reg;      // Register address from the second byte
  logic [7:0]  regPtr_next;
  logic        sdaLow_reg;      // Pull the data line low
  logic        sdaLow_next;
  logic [7:0]  control_reg;     // general_control contents
  logic [7:0]  control_next;

  // Decoded sink state
  logic        primaryOn_reg;   // Primary sink active
  logic        primaryOn_next;
  logic        secondaryOn_reg; // Secondary sink active
  logic        secondaryOn_next;
  logic        shared_reg;      // Secondary level taken from primary register
  logic        shared_next;
  logic        feedback_reg;    // Secondary pin used as feedback input
  logic        feedback_next;
  logic        analog_reg;      // Analog circuitry enabled
  logic        analog_next;
  logic [1:0]  rate_reg;        // Ramp rate selector
  logic [1:0]  rate_next;

  // Ramp step timer
  logic [23:0] rampCount_reg;   // Cycles into the current step
  logic [23:0] rampCount_next;
  logic        rampTick_reg;    // One-cycle pulse per step
  logic        rampTick_next;
  logic [23:0] stepLimit;       // Period of the selected rate

  // Read value of the register that the pointer selects
  function automatic logic [7:0] regRead(input logic [7:0] ptr, input logic [7:0] ctl);
    regRead = (ptr == GC_ADDR) ? ctl : UNMAPPED_READ;
  endfunction

  // Pin synchronisers
  pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pinIn   ({sclIn, sdaIn}),
    .pinSync (pinSync)
  );

  // Start, stop and clock edge pulses
  bus_condition_detect u_detect (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .sclSync (pinSync[1]),
    .sdaSync (pinSync[0]),
    .ev      (ev.source)
  );

  // Slave byte engine and register write
  always_comb begin
    state_next    = state_reg;
    afterAck_next = afterAck_reg;
    shift_next    = shift_reg;
    bitCount_next = bitCount_reg;
    regPtr_next   = regPtr_reg;
    sdaLow_next   = sdaLow_reg;
    control_next  = control_reg;
    if (ev.stopSeen) begin
      // Stop frees the bus and releases the line
      state_next  = ST_IDLE;
      sdaLow_next = 1'b0;
    end else if (ev.startSeen) begin
      // Start or repeated start begins a new address byte
      state_next    = ST_ADDR;
      bitCount_next = 4'h0;
      shift_next    = 8'h00;
      sdaLow_next   = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (ev.sclRise) begin
            // Sample data, most significant bit first
            shift_next    = {shift_reg[6:0], ev.sdaLevel};
            bitCount_next = bitCount_reg + 4'h1;
          end else if (ev.sclFall && bitCount_reg == BYTE_BITS) begin
            // Byte complete: acknowledge and act on it
            bitCount_next = 4'h0;
            state_next    = ST_ACK;
            sdaLow_next   = 1'b1;
            afterAck_next = ST_WDATA;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] != DEV_ADDR) begin
                // Not our address: stay off the bus
                state_next  = ST_IDLE;
                sdaLow_next = 1'b0;
              end else if (shift_reg[0]) begin
                afterAck_next = ST_RDATA;
              end else begin
                afterAck_next = ST_REG;
              end
            end else if (state_reg == ST_REG) begin
              regPtr_next = shift_reg;
            end else if (regPtr_reg == GC_ADDR) begin
              // Bits 7:6 forced high whatever is written
              control_next = shift_reg | GC_FIXED_MASK;
            end
          end
        end
        ST_ACK: begin
          if (ev.sclFall) begin
            // End of acknowledge: release, or drive first read bit
            state_next    = afterAck_reg;
            bitCount_next = 4'h0;
            sdaLow_next   = 1'b0;
            if (afterAck_reg == ST_RDATA) begin
              shift_next  = regRead(regPtr_reg, control_reg);
              sdaLow_next = ~shift_next[7];
            end
          end
        end
        ST_RDATA: begin
          if (ev.sclRise) begin
            bitCount_next = bitCount_reg + 4'h1;
          end else if (ev.sclFall) begin
            if (bitCount_reg == BYTE_BITS) begin
              // Hand the line to the master for its acknowledge
              sdaLow_next   = 1'b0;
              bitCount_next = 4'h0;
              state_next    = ST_MACK;
            end else begin
              shift_next  = {shift_reg[6:0], 1'b0};
              sdaLow_next = ~shift_reg[6];
            end
          end
        end
        ST_MACK: begin
          if (ev.sclRise && ev.sdaLevel) begin
            // Master refused: read ends
            state_next = ST_IDLE;
          end else if (ev.sclFall) begin
            // Master acknowledged: send the register again
            state_next  = ST_RDATA;
            shift_next  = regRead(regPtr_reg, control_reg);
            sdaLow_next = ~shift_next[7];
          end
        end
        default: begin
          // Idle: wait for a start
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Slave and register flip-flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_IDLE;
      afterAck_reg <= ST_IDLE;
      shift_reg    <= 8'h00;
      bitCount_reg <= 4'h0;
      regPtr_reg   <= 8'h00;
      sdaLow_reg   <= 1'b0;
      control_reg  <= GC_RESET;
    end else begin
      state_reg    <= state_next;
      afterAck_reg <= afterAck_next;
      shift_reg    <= shift_next;
      bitCount_reg <= bitCount_next;
      regPtr_reg   <= regPtr_next;
      sdaLow_reg   <= sdaLow_next;
      control_reg  <= control_next;
    end
  end

  // Sink decode from the control bits
  always_comb begin
    // Primary follows its enable in every mode
    primaryOn_next = control_reg[PRIMARY_EN_BIT];
    if (control_reg[DISPLAY_BIAS_BIT]) begin
      // Secondary pin becomes feedback input
      secondaryOn_next = 1'b0;
    end else if (control_reg[SHARED_LEVEL_BIT]) begin
      // Shared level: secondary follows the primary enable
      secondaryOn_next = control_reg[PRIMARY_EN_BIT];
    end else begin
      // Independent: secondary follows its own enable
      secondaryOn_next = control_reg[SECONDARY_EN_BIT];
    end
    shared_next   = control_reg[SHARED_LEVEL_BIT];
    feedback_next = control_reg[DISPLAY_BIAS_BIT];
    analog_next   = control_reg[PRIMARY_EN_BIT] | control_reg[SECONDARY_EN_BIT]
                  | control_reg[DISPLAY_BIAS_BIT];
    rate_next     = {control_reg[RAMP_HIGH_BIT], control_reg[RAMP_LOW_BIT]};
  end

  // Decode flip-flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      primaryOn_reg   <= 1'b0;
      secondaryOn_reg <= 1'b0;
      shared_reg      <= 1'b0;
      feedback_reg    <= 1'b0;
      analog_reg      <= 1'b0;
      rate_reg        <= 2'h0;
    end else begin
      primaryOn_reg   <= primaryOn_next;
      secondaryOn_reg <= secondaryOn_next;
      shared_reg      <= shared_next;
      feedback_reg    <= feedback_next;
      analog_reg      <= analog_next;
      rate_reg        <= rate_next;
    end
  end

  // Step timer paced by the selected ramp rate
  always_comb begin
    case (rate_reg)
      2'h0:    stepLimit = STEP_CYCLES_A;
      2'h2:    stepLimit = STEP_CYCLES_B;
      2'h1:    stepLimit = STEP_CYCLES_C;
      default: stepLimit = STEP_CYCLES_D;
    endcase
    // A shorter rate chosen mid-step ends the step at its own period, or at once if the count is already past it
    if (rampCount_reg >= stepLimit - 24'h1) begin
      rampCount_next = 24'h0;
      rampTick_next  = 1'b1;
    end else begin
      rampCount_next = rampCount_reg + 24'h1;
      rampTick_next  = 1'b0;
    end
  end

  // Step timer flip-flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rampCount_reg <= 24'h0;
      rampTick_reg  <= 1'b0;
    end else begin
      rampCount_reg <= rampCount_next;
      rampTick_reg  <= rampTick_next;
    end
  end

  // Open-drain data pin: value always low, enable low while pulling
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOut  <= 1'b0;
      sdaOe_b <= 1'b1;
    end else begin
      sdaOut  <= 1'b0;
      sdaOe_b <= ~sdaLow_next;
    end
  end

  // Outputs straight from flip-flops
  assign primarySinkOn             = primaryOn_reg;
  assign secondarySinkOn           = secondaryOn_reg;
  assign secondaryLevelFromPrimary = shared_reg;
  assign feedbackMode              = feedback_reg;
  assign analogEnable              = analog_reg;
  assign rampRate                  = rate_reg;
  assign rampStepTick              = rampTick_reg;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  reset_value_a: assert property (!$past(rst_b) |-> control_reg == GC_RESET)
    else $error("control register not at power-on value");
  fixed_bits_a: assert property (control_reg[7:6] == 2'b11)
    else $error("unused control bits not high");
  write_primary_a: assert property (
    (state_reg == ST_WDATA && ev.sclFall && bitCount_reg == BYTE_BITS && regPtr_reg == GC_ADDR)
    |=> (control_reg[PRIMARY_EN_BIT] == $past(shift_reg[PRIMARY_EN_BIT]))
    ##1 (primarySinkOn == $past(control_reg[PRIMARY_EN_BIT])))
    else $error("primary sink does not follow written enable");
  bias_mode_a: assert property ($past(control_reg[DISPLAY_BIAS_BIT]) |->
    !secondarySinkOn && feedbackMode && primarySinkOn == $past(control_reg[PRIMARY_EN_BIT]))
    else $error("display-bias mode decode wrong");
  shared_on_a: assert property (
    ($past(control_reg[5:0]) & 6'h24) == 6'h04 |->
    secondarySinkOn == primarySinkOn && secondaryLevelFromPrimary)
    else $error("shared-level sinks differ");
  independent_sink_a: assert property (
    ($past(control_reg[5:0]) & 6'h24) == 6'h00 |->
    secondarySinkOn == $past(control_reg[SECONDARY_EN_BIT]) && !secondaryLevelFromPrimary)
    else $error("independent secondary sink wrong");
  only_primary_a: assert property (($past(control_reg[5:0]) & 6'h27) == 6'h01 |->
    primarySinkOn && !secondarySinkOn)
    else $error("primary-only decode wrong");
  analog_enable_a: assert property (analogEnable ==
    |($past(control_reg) & 8'h23))
    else $error("analog enable wrong");
  ramp_select_a: assert property (rampRate == $past(control_reg[4:3]))
    else $error("ramp selector wrong");
  // The pull stands for every cycle of the acknowledge slot
  ack_drive_a: assert property ((state_reg == ST_ACK) |-> sdaLow_reg && !sdaOe_b)
    else $error("acknowledge not driven");

  write_seen_c: cover property (state_reg == ST_WDATA && ev.sclFall && regPtr_reg == GC_ADDR);
  read_seen_c: cover property (state_reg == ST_RDATA && ev.sclFall);
  bias_mode_c: cover property (feedbackMode && primarySinkOn);
  shared_mode_c: cover property (secondaryLevelFromPrimary && secondarySinkOn);

endmodule

// >>> i2c_master_model.sv
// Bus master model driving the two-wire control bus of the LED sink block
`timescale 1ns/100ps
module i2c_master_model
  import led_ctrl_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sdaWire,
  output logic      sclOut,
  output logic      sdaRel
);
  // Idle bus: both lines released to the pull-up level
  initial begin
    sclOut = 1'b1;
    sdaRel = 1'b1;
  end

  // Wait a number of system clock edges
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic start_cond();
    sdaRel <= 1'b1;
    cyc(3);
    sclOut <= 1'b1;
    cyc(6);
    sdaRel <= 1'b0;
    cyc(6);
    sclOut <= 1'b0;
    cyc(3);
  endtask

  // Stop: data rises while clock is high, bus left free
  task automatic stop_cond();
    sdaRel <= 1'b0;
    cyc(3);
    sclOut <= 1'b1;
    cyc(6);
    sdaRel <= 1'b1;
    cyc(6);
  endtask

  // One bit: data set while clock low, sampled mid high phase
  task automatic bit_xfer(input logic b, output logic r);
    sdaRel <= b;
    cyc(3);
    sclOut <= 1'b1;
    cyc(4);
    r = sdaWire;
    cyc(4);
    sclOut <= 1'b0;
    cyc(3);
  endtask

  // Byte MSB first, then the acknowledge slot
  task automatic byte_xfer(input logic [7:0] d, input logic ackRel, output logic [7:0] r,
                           output logic ackLow);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r[i]);
    end
    bit_xfer(ackRel, a);
    ackLow = ~a;
  endtask

  // Register write: device address, register address, data byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                           output logic [2:0] acks);
    logic [7:0] r;
    start_cond();
    byte_xfer({dev, 1'b0}, 1'b1, r, acks[2]);
    byte_xfer(ra, 1'b1, r, acks[1]);
    byte_xfer(d, 1'b1, r, acks[0]);
    stop_cond();
  endtask

  // Register read through a repeated start, ended by a not-acknowledge
  task automatic read_reg(input logic [7:0] ra, output logic [7:0] d);
    logic a;
    start_cond();
    byte_xfer({DEV_ADDR, 1'b0}, 1'b1, d, a);
    byte_xfer(ra, 1'b1, d, a);
    start_cond();
    byte_xfer({DEV_ADDR, 1'b1}, 1'b1, d, a);
    byte_xfer(8'hff, 1'b1, d, a);
    stop_cond();
  endtask
endmodule

// >>> tb_led_sink_general_control_register.sv
// Self-checking bench for the LED sink general control register
`timescale 1ns/100ps
module tb_led_sink_general_control_register
  import led_ctrl_pkg::*;
;
  localparam logic [23:0] STEP_A = 24'h8;  // Short ramp step periods
  localparam logic [23:0] STEP_B = 24'h10;
  localparam logic [23:0] STEP_C = 24'h18;
  localparam logic [23:0] STEP_D = 24'h20;
  logic       ref_clk, rst_b, sclLine, masterSda, sdaWire;  // Clock, reset, bus lines
  logic       sdaOut, sdaOe_b, primarySinkOn, secondarySinkOn;
  logic       secondaryLevelFromPrimary, feedbackMode, analogEnable, rampStepTick;
  logic [1:0] rampRate;
  logic [7:0] rd, ctrlExp, v, seenOut;  // Read data, expected register, stimulus
  logic [2:0] acks;                     // Acknowledges of one write
  int         errors, checked, seed;

  // Open-drain wire with pull-up
  assign sdaWire = sdaOe_b & masterSda;
  // Decode outputs packed like the expectation
  assign seenOut = {1'b0, primarySinkOn, secondarySinkOn, secondaryLevelFromPrimary,
                    feedbackMode, analogEnable, rampRate};

  led_sink_general_control_register #(
    .STEP_CYCLES_A(STEP_A), .STEP_CYCLES_B(STEP_B),
    .STEP_CYCLES_C(STEP_C), .STEP_CYCLES_D(STEP_D)
  ) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .sclIn(sclLine), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .primarySinkOn(primarySinkOn),
    .secondarySinkOn(secondarySinkOn), .secondaryLevelFromPrimary(secondaryLevelFromPrimary),
    .feedbackMode(feedbackMode), .analogEnable(analogEnable), .rampRate(rampRate),
    .rampStepTick(rampStepTick)
  );

  i2c_master_model u_master (
    .ref_clk(ref_clk), .sdaWire(sdaWire), .sclOut(sclLine), .sdaRel(masterSda)
  );

  // Expected outputs from a register value
  function automatic logic [7:0] decode(input logic [7:0] c);
    logic sec;
    sec = ~c[5] & (c[2] ? c[0] : c[1]);
    return {1'b0, c[0], sec, c[2], c[5], c[0] | c[1] | c[5], c[4], c[3]};
  endfunction

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Compare all decode outputs against a register value
  task automatic check_decode(input logic [7:0] c);
    logic [7:0] e;
    e = decode(c);
    check({6'h0, seenOut[6:5]}, {6'h0, e[6:5]}, "sinks");
    check({5'h0, seenOut[6:4]}, {5'h0, e[6:4]}, "truth");
    check({5'h0, seenOut[4:2]}, {5'h0, e[4:2]}, "mode");
    check({6'h0, rampRate}, {6'h0, e[1:0]}, "ramp bits");
  endtask

  // Write the control register, then check acks, decode and read-back
  task automatic put_check(input logic [7:0] d);
    u_master.write_reg(DEV_ADDR, GC_ADDR, d, acks);
    check({5'h0, acks}, 8'h07, "acks");
    ctrlExp = {2'b11, d[5:0]};
    check_decode(ctrlExp);
    u_master.read_reg(GC_ADDR, rd);
    check(rd, ctrlExp, "readback");
  endtask

  // Measure cycles between ramp step pulses, bounded
  task automatic tick_check(input logic [7:0] period);
    int n;
    n = 0;
    // Sampled on the falling edge, where the pulse has settled
    while (rampStepTick !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      final_report();
    end
    @(negedge ref_clk);
    n = 1;
    while (rampStepTick !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    check(8'(n), period, "step period");
  endtask

  // Counts, verdict and end of run
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Main sequence
  initial begin
    errors = 0;
    checked = 0;
    seed = 79;
    rst_b = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check_decode(GC_RESET);
    check({6'h0, sdaOe_b, sdaOut}, 8'h02, "bus idle");
    u_master.read_reg(GC_ADDR, rd);
    check(rd, GC_RESET, "reset value");
    $display("Test reset done");
    // Every functional combination, random upper bits
    for (int i = 0; i < 64; i++) begin
      v = 8'($random(seed));
      v[5:0] = 6'(i);
      put_check(v);
    end
    $display("Test truth table done");
    // Each ramp rate and its step period
    for (int r = 0; r < 4; r++) begin
      put_check({3'h0, 2'(r), 3'h0});
      tick_check(r == 0 ? 8'h8 : r == 1 ? 8'h18 : r == 2 ? 8'h10 : 8'h20);
    end
    $display("Test ramp rates done");
    // Foreign device address is ignored
    put_check(8'h07);
    u_master.write_reg(DEV_ADDR ^ 7'h01, GC_ADDR, 8'h20, acks);
    check({5'h0, acks}, 8'h00, "foreign acks");
    check_decode(ctrlExp);
    // Unmapped register accepted but dropped
    u_master.write_reg(DEV_ADDR, 8'h55, 8'h22, acks);
    check({5'h0, acks}, 8'h07, "unmapped acks");
    check_decode(ctrlExp);
    u_master.read_reg(8'h55, rd);
    check(rd, UNMAPPED_READ, "unmapped read");
    $display("Test refusals done");
    // Reset in mid-run restores power-on state
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check_decode(GC_RESET);
    u_master.read_reg(GC_ADDR, rd);
    check(rd, GC_RESET, "second reset");
    $display("Test second reset done");
    final_report();
  end
endmodule
